/* pkg/host_bus_consts.svh */
// Address map, reset values and timing counts of the host bus port
`ifndef HOST_BUS_CONSTS_SVH
`define HOST_BUS_CONSTS_SVH

`define HB_CLK_MHZ 100
`define HB_HOLDOFF_NS 1000
`define HB_HOLDOFF_CYC ((`HB_HOLDOFF_NS * `HB_CLK_MHZ + 999) / 1000)
`define HB_HOLDOFF_W 7

`define HB_ADDR_W 7
`define HB_DATA_W 8
`define HB_CHAN_W 2
`define HB_MODEM_W 4
`define HB_SVC_W 3
`define HB_RAM_IDX_W 9

`define HB_WINDOW_BIT 6
`define HB_ADDR_CHAN_PTR 7'h3C
`define HB_ADDR_SVC_END 7'h3D
`define HB_ADDR_SVC_STATUS 7'h3E
`define HB_ADDR_MODEM 7'h3F
`define HB_ADDR_VEC_BASE 7'h40

`define HB_RST_CHAN_PTR 2'h0
`define HB_RST_SVC_STATUS 3'h0
`define HB_RST_DATA 8'h00

`endif

/* pkg/host_bus_pkg.sv */
// Types of the host bus port
package host_bus_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_C1 = 3'h1,
      ST_C2 = 3'h3,
      ST_C3 = 3'h2,
      ST_C4 = 3'h6,
      ST_DONE = 3'h7
   } cycle_state_e;
endpackage

/* pkg/reg_bank_if.sv */
// Link between the cycle sequencer and the register bank
`include "host_bus_consts.svh"
interface reg_bank_if;
   logic [`HB_ADDR_W-1:0] addr;
   logic wr_stb;
   logic [`HB_DATA_W-1:0] wr_data;
   logic svc_stb;
   logic [`HB_CHAN_W-1:0] req_chan;
   logic [`HB_MODEM_W-1:0] modem;
   logic [`HB_DATA_W-1:0] rd_data;
   logic [`HB_SVC_W-1:0] svc_req;
   modport core (output addr, wr_stb, wr_data, svc_stb, req_chan, modem,
                 input rd_data, svc_req);
   modport bank (input addr, wr_stb, wr_data, svc_stb, req_chan, modem,
                 output rd_data, svc_req);
endinterface

/* core/reg_bank.sv */
// Register bank: RAM array windowed by the channel pointer, plus live locations
`include "host_bus_consts.svh"
module reg_bank (
   input wire logic mclk_in,
   input wire logic nrst_in,
   reg_bank_if.bank rb
);
   logic [`HB_DATA_W-1:0] ram [0:(1 << `HB_RAM_IDX_W)-1];
   logic [`HB_CHAN_W-1:0] chan_ptr;
   logic [`HB_CHAN_W-1:0] next_chan_ptr;
   logic [`HB_SVC_W-1:0] svc_status;
   logic [`HB_SVC_W-1:0] next_svc_status;
   logic [`HB_RAM_IDX_W-1:0] idx;
   logic windowed;

   assign windowed = rb.addr[`HB_WINDOW_BIT];
   // Channel pointer forms the upper part of the internal address of windowed locations; others use channel 0
   assign idx = {windowed, (windowed ? chan_ptr : `HB_RST_CHAN_PTR),
                 rb.addr[`HB_WINDOW_BIT-1:0]};
   assign rb.svc_req = svc_status;

   always_comb begin
      next_chan_ptr = chan_ptr;
      next_svc_status = svc_status;
      if (rb.svc_stb) begin
         next_chan_ptr = rb.req_chan;
      end else if (rb.wr_stb && rb.addr == `HB_ADDR_CHAN_PTR) begin
         next_chan_ptr = rb.wr_data[`HB_CHAN_W-1:0];
      end
      if (rb.wr_stb && rb.addr == `HB_ADDR_SVC_STATUS) begin
         next_svc_status = rb.wr_data[`HB_SVC_W-1:0];
      end
   end

   always_comb begin
      unique case (rb.addr)
         `HB_ADDR_CHAN_PTR: rb.rd_data = {{(`HB_DATA_W-`HB_CHAN_W){1'h0}}, chan_ptr};
         `HB_ADDR_SVC_END: rb.rd_data = `HB_RST_DATA;
         `HB_ADDR_SVC_STATUS: rb.rd_data = {{(`HB_DATA_W-`HB_SVC_W){1'h0}}, svc_status};
         `HB_ADDR_MODEM: rb.rd_data = {{(`HB_DATA_W-`HB_MODEM_W){1'h0}}, rb.modem};
         default: rb.rd_data = ram[idx];
      endcase
   end

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         chan_ptr <= `HB_RST_CHAN_PTR;
         svc_status <= `HB_RST_SVC_STATUS;
      end else begin
         chan_ptr <= next_chan_ptr;
         svc_status <= next_svc_status;
      end
   end

   // RAM has no reset; contents are undefined until written
   always_ff @(posedge mclk_in) begin
      if (rb.wr_stb) begin
         ram[idx] <= rb.wr_data;
      end
   end
endmodule // reg_bank

/* core/host_bus_cycle_interface.sv */
// Host bus cycle sequencer with daisy chain and hold-off
`include "host_bus_consts.svh"
module host_bus_cycle_interface (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic cs_n_in,
   input wire logic data_strobe_n_in,
   input wire logic rw_in,
   input wire logic [`HB_ADDR_W-1:0] addr_in,
   input wire logic [`HB_DATA_W-1:0] data_in,
   input wire logic [`HB_SVC_W-1:0] service_ack_n_in,
   input wire logic chain_grant_n_in,
   input wire logic [`HB_MODEM_W-1:0] modem_in,
   input wire logic [`HB_CHAN_W-1:0] req_chan_in,
   output logic [`HB_DATA_W-1:0] data_out,
   output logic data_oe_out,
   output logic transfer_ack_n_out,
   output logic chain_pass_n_out,
   output logic [`HB_SVC_W-1:0] svc_req_n_out
);
   localparam int PIN_W = 3 + `HB_ADDR_W + `HB_DATA_W + `HB_SVC_W + 1 + `HB_MODEM_W;

   reg_bank_if rb ();

   logic [PIN_W-1:0] pin_meta;
   logic [PIN_W-1:0] pin_sync;
   logic s_cs_n;
   logic s_ds_n;
   logic s_rw;
   logic [`HB_ADDR_W-1:0] s_addr;
   logic [`HB_DATA_W-1:0] s_data;
   logic [`HB_SVC_W-1:0] s_svc_n;
   logic s_grant_n;
   logic [`HB_MODEM_W-1:0] s_modem;

   host_bus_pkg::cycle_state_e state;
   host_bus_pkg::cycle_state_e next_state;
   logic phase;
   logic next_phase;
   logic kind_svc;
   logic next_kind_svc;
   logic is_wr;
   logic next_is_wr;
   logic [`HB_ADDR_W-1:0] addr_lat;
   logic [`HB_ADDR_W-1:0] next_addr_lat;
   logic [`HB_HOLDOFF_W-1:0] holdoff;
   logic [`HB_HOLDOFF_W-1:0] next_holdoff;
   logic [`HB_DATA_W-1:0] next_data;
   logic next_oe;
   logic next_ack_n;
   logic next_pass_n;
   logic [`HB_SVC_W-1:0] next_req_n;
   logic wr_stb;
   logic svc_stb;
   logic ack_now;

   logic fall;
   logic cs_act;
   logic ds_act;
   logic grant_act;
   logic [`HB_SVC_W-1:0] svc_act;
   logic svc_hit;
   logic cyc_on;
   logic [`HB_ADDR_W-1:0] vec_addr;

   // Two-stage synchroniser on every pin input except req_chan_in, which goes to the bank unsynchronised
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pin_meta <= {PIN_W{1'h1}};
         pin_sync <= {PIN_W{1'h1}};
      end else begin
         pin_meta <= {cs_n_in, data_strobe_n_in, rw_in, addr_in, data_in,
                      service_ack_n_in, chain_grant_n_in, modem_in};
         pin_sync <= pin_meta;
      end
   end

   assign {s_cs_n, s_ds_n, s_rw, s_addr, s_data, s_svc_n, s_grant_n, s_modem} = pin_sync;

   assign rb.addr = addr_lat;
   assign rb.wr_data = s_data;
   assign rb.wr_stb = wr_stb;
   assign rb.svc_stb = svc_stb;
   assign rb.req_chan = req_chan_in;
   assign rb.modem = s_modem;

   reg_bank u_bank (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .rb(rb.bank)
   );

   assign fall = phase;
   assign cs_act = ~s_cs_n;
   assign ds_act = ~s_ds_n;
   assign grant_act = ~s_grant_n;
   assign svc_act = ~s_svc_n;
   assign svc_hit = |(svc_act & rb.svc_req);
   assign cyc_on = ds_act & (kind_svc ? grant_act : cs_act);

   // Vector location of the acknowledged request type, lowest type first
   always_comb begin
      vec_addr = `HB_ADDR_VEC_BASE;
      for (int i = `HB_SVC_W - 1; i >= 0; i--) begin
         if (svc_act[i]) begin
            vec_addr = `HB_ADDR_VEC_BASE + `HB_ADDR_W'(i);
         end
      end
   end

   always_comb begin
      next_state = state;
      next_phase = ~phase;
      next_kind_svc = kind_svc;
      next_is_wr = is_wr;
      next_addr_lat = addr_lat;
      next_holdoff = holdoff;
      next_data = data_out;
      next_oe = data_oe_out;
      next_ack_n = transfer_ack_n_out;
      next_req_n = ~rb.svc_req;
      next_pass_n = ~(ds_act & grant_act & ~svc_hit);
      wr_stb = 1'h0;
      svc_stb = 1'h0;
      ack_now = 1'h0;
      if (holdoff != `HB_HOLDOFF_W'(0)) begin
         next_holdoff = holdoff - `HB_HOLDOFF_W'(1);
      end
      unique case (state)
         host_bus_pkg::ST_IDLE: begin
            // Late strobes are simply caught at the next fall
            if (fall && ds_act && cs_act) begin
               next_state = host_bus_pkg::ST_C1;
               next_kind_svc = 1'h0;
               next_is_wr = ~s_rw;
               next_addr_lat = s_addr;
            end else if (fall && ds_act && grant_act && svc_hit) begin
               next_state = host_bus_pkg::ST_C1;
               next_kind_svc = 1'h1;
               next_is_wr = 1'h0;
               next_addr_lat = vec_addr;
               svc_stb = 1'h1;
            end
         end
         host_bus_pkg::ST_C1: begin
            if (fall) begin
               next_state = host_bus_pkg::ST_C2;
            end
         end
         host_bus_pkg::ST_C2: begin
            // Fall of the third cycle
            if (fall) begin
               next_state = host_bus_pkg::ST_C3;
               if (!is_wr) begin
                  next_data = rb.rd_data;
                  next_oe = 1'h1;
               end
            end
         end
         host_bus_pkg::ST_C3: begin
            // Fall of the fourth cycle; ST_DONE waits out the hold-off
            if (fall) begin
               next_state = host_bus_pkg::ST_DONE;
               if (holdoff == `HB_HOLDOFF_W'(0)) begin
                  next_state = host_bus_pkg::ST_C4;
                  ack_now = 1'h1;
               end
            end
         end
         host_bus_pkg::ST_DONE: begin
            if (fall && holdoff == `HB_HOLDOFF_W'(0)) begin
               next_state = host_bus_pkg::ST_C4;
               ack_now = 1'h1;
            end
         end
         host_bus_pkg::ST_C4: begin
         end
         default: begin
            next_state = host_bus_pkg::ST_IDLE;
         end
      endcase
      if (ack_now) begin
         next_ack_n = 1'h0;
         wr_stb = is_wr;
         if (kind_svc || (is_wr && addr_lat == `HB_ADDR_SVC_END)) begin
            next_holdoff = `HB_HOLDOFF_W'(`HB_HOLDOFF_CYC);
         end
      end
      if (state != host_bus_pkg::ST_IDLE && !cyc_on) begin
         next_state = host_bus_pkg::ST_IDLE;
         next_oe = 1'h0;
         next_ack_n = 1'h1;
         wr_stb = 1'h0;
      end
   end

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= host_bus_pkg::ST_IDLE;
         phase <= 1'h0;
         kind_svc <= 1'h0;
         is_wr <= 1'h0;
         addr_lat <= `HB_ADDR_W'(0);
         holdoff <= `HB_HOLDOFF_W'(0);
         data_out <= `HB_RST_DATA;
         data_oe_out <= 1'h0;
         transfer_ack_n_out <= 1'h1;
         chain_pass_n_out <= 1'h1;
         svc_req_n_out <= {`HB_SVC_W{1'h1}};
      end else begin
         state <= next_state;
         phase <= next_phase;
         kind_svc <= next_kind_svc;
         is_wr <= next_is_wr;
         addr_lat <= next_addr_lat;
         holdoff <= next_holdoff;
         data_out <= next_data;
         data_oe_out <= next_oe;
         transfer_ack_n_out <= next_ack_n;
         chain_pass_n_out <= next_pass_n;
         svc_req_n_out <= next_req_n;
      end
   end
endmodule // host_bus_cycle_interface

/* tb/host_bus_asserts.sv */
// Checker of host bus cycle timing, bound to the top module
`include "host_bus_consts.svh"
module host_bus_asserts (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic cs_n_in,
   input wire logic data_strobe_n_in,
   input wire logic rw_in,
   input wire logic [`HB_ADDR_W-1:0] addr_in,
   input wire logic [`HB_DATA_W-1:0] data_in,
   input wire logic [`HB_SVC_W-1:0] service_ack_n_in,
   input wire logic chain_grant_n_in,
   input wire logic data_oe_out,
   input wire logic transfer_ack_n_out,
   input wire logic chain_pass_n_out,
   input wire logic [`HB_SVC_W-1:0] svc_req_n_out
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HOLD = `HB_HOLDOFF_CYC - 2;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   logic ack_q;
   logic trig;
   logic [7:0] since;
   logic [7:0] next_since;
   // Cycles since the last ack that starts a hold-off
   assign trig = cs_n_in ? service_ack_n_in != 3'h7 : !rw_in && addr_in == `HB_ADDR_SVC_END;
   always_comb begin
      next_since = (since == 8'hFF) ? since : since + 8'h01;
      if (ack_q && !transfer_ack_n_out && trig) next_since = 8'h00;
   end
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         since <= 8'hFF;
         ack_q <= 1'b1;
      end else begin
         since <= next_since;
         ack_q <= transfer_ack_n_out;
      end
   end
   sequence s_gone;
      data_strobe_n_in [*4];
   endsequence
   sequence s_ack_fall;
      $fell(transfer_ack_n_out);
   endsequence
   property p_release; s_gone |-> !data_oe_out; endproperty
   property p_ack_off; s_gone |-> transfer_ack_n_out; endproperty
   property p_ack_cause; s_ack_fall |-> !$past(data_strobe_n_in, 8); endproperty
   property p_data_first;
      $rose(data_oe_out) && since == 8'hFF |-> rw_in ##2 $fell(transfer_ack_n_out);
   endproperty
   property p_holdoff; s_ack_fall |-> since >= HOLD; endproperty
   property p_pass_on;
      !chain_pass_n_out |-> !$past(chain_grant_n_in, 2) || !$past(chain_grant_n_in, 3);
   endproperty
   property p_pass_off; chain_grant_n_in [*4] |-> chain_pass_n_out; endproperty
   property p_svc_out;
      s_ack_fall ##0 (!cs_n_in && !rw_in && addr_in == `HB_ADDR_SVC_STATUS)
         |-> ##2 svc_req_n_out == ~$past(data_in[`HB_SVC_W-1:0], 2);
   endproperty
   a_release: assert property (p_release) else $error("bus kept driven");
   a_ack_off: assert property (p_ack_off) else $error("ack kept low");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");
   a_data_first: assert property (p_data_first) else $error("read timing off");
   a_holdoff: assert property (p_holdoff) else $error("hold-off too short");
   a_pass_on: assert property (p_pass_on) else $error("pass without grant");
   a_pass_off: assert property (p_pass_off) else $error("pass kept low");
   a_svc_out: assert property (p_svc_out) else $error("request pins wrong");
endmodule // host_bus_asserts
bind host_bus_cycle_interface host_bus_asserts chk (.mclk_in, .nrst_in, .cs_n_in,
   .data_strobe_n_in, .rw_in, .addr_in, .data_in, .service_ack_n_in, .chain_grant_n_in,
   .data_oe_out, .transfer_ack_n_out, .chain_pass_n_out, .svc_req_n_out);

/* tb/host_model.sv */
// Host CPU model driving bus cycles and waiting on the acknowledge
module host_model (
   input wire logic mclk_in,
   input wire logic ack_n_in,
   input wire logic pass_n_in,
   output logic cs_n_out,
   output logic ds_n_out,
   output logic rw_out,
   output logic [6:0] addr_out,
   output logic [7:0] data_out,
   output logic [2:0] sack_n_out,
   output logic grant_n_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {cs_n_out, ds_n_out, rw_out, grant_n_out} = 4'hF;
      addr_out = 7'h00;
      data_out = 8'h00;
      sack_n_out = 3'h7;
   end
   task automatic idle(input logic [7:0] d, input logic [6:0] a);
      {cs_n_out, ds_n_out, grant_n_out} = 3'h7;
      sack_n_out = 3'h7;
      data_out = ~d;
      addr_out = ~a;
      for (int i = 0; i < 6 && ack_n_in !== 1'b1; i++) @(posedge mclk_in);
   endtask
   task automatic cycle(input logic svc, input logic rw, input logic [6:0] a,
                        input logic [7:0] d, input logic [2:0] sk, output int lat);
      lat = 0;
      @(posedge mclk_in) #1;
      rw_out = rw;
      addr_out = a;
      data_out = d;
      sack_n_out = sk;
      @(posedge mclk_in) #1;
      if (svc) grant_n_out = 1'b0;
      else cs_n_out = 1'b0;
      ds_n_out = 1'b0;
      do begin
         @(posedge mclk_in);
         lat++;
      end while (ack_n_in !== 1'b0 && lat < 400);
      #1;
      idle(d, a);
   endtask
   task automatic offer(input logic [2:0] sk, output logic p);
      @(posedge mclk_in) #1;
      sack_n_out = sk;
      @(posedge mclk_in) #1;
      grant_n_out = 1'b0;
      ds_n_out = 1'b0;
      repeat (8) @(posedge mclk_in);
      p = pass_n_in;
      #1;
      idle(data_out, addr_out);
   endtask
endmodule // host_model

/* tb/testbench.sv */
// Self-checking bench of the host bus cycle interface
`include "host_bus_consts.svh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic cs_n, ds_n, rw, grant_n, ack_n, pass_n, oe, p;
   logic ack_q = 1'b1;
   logic [6:0] addr;
   logic [7:0] hdata, rdata;
   logic [7:0] mem [4];
   logic [2:0] sack_n, sreq_n;
   logic [3:0] modem = 4'h0;
   logic [1:0] chan = 2'h0;
   logic [7:0] exp_q [$];
   int n_mismatch = 0;
   int compares = 0;
   int lat;
   initial forever #5 mclk_in = ~mclk_in;
   host_model host (.mclk_in(mclk_in), .ack_n_in(ack_n), .pass_n_in(pass_n), .cs_n_out(cs_n),
      .ds_n_out(ds_n), .rw_out(rw), .addr_out(addr), .data_out(hdata), .sack_n_out(sack_n),
      .grant_n_out(grant_n));
   host_bus_cycle_interface dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .cs_n_in(cs_n),
      .data_strobe_n_in(ds_n), .rw_in(rw), .addr_in(addr), .data_in(oe ? rdata : hdata),
      .service_ack_n_in(sack_n), .chain_grant_n_in(grant_n), .modem_in(modem),
      .req_chan_in(chan), .data_out(rdata), .data_oe_out(oe), .transfer_ack_n_out(ack_n),
      .chain_pass_n_out(pass_n), .svc_req_n_out(sreq_n));
   task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic tally_and_finish;
      if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic go(input logic svc, input logic r, input logic [6:0] a, input logic [7:0] d,
                     input logic [2:0] sk);
      host.cycle(svc, r, a, d, sk, lat);
      if (lat >= 400 || ack_n !== 1'b1) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask
   task automatic rd(input logic svc, input logic [6:0] a, input logic [7:0] e,
                     input logic [2:0] sk);
      exp_q.push_back(e);
      go(svc, 1'b1, a, 8'h00, sk);
   endtask
   // Read data taken at the edge where the acknowledge is first seen
   always @(posedge mclk_in) begin
      ack_q <= ack_n;
      if (ack_q === 1'b1 && ack_n === 1'b0 && oe === 1'b1)
         check("read data", exp_q.pop_front(), rdata);
   end
   initial begin
      void'($urandom(32'hED54C656));
      repeat (6) @(posedge mclk_in);
      #1 nrst_in = 1'b1;
      for (int i = 0; i < 4; i++) begin
         mem[i] = 8'($urandom);
         go(1'b0, 1'b0, 7'(i * 9), mem[i], 3'h7);
      end
      for (int i = 0; i < 4; i++) rd(1'b0, 7'(i * 9), mem[i], 3'h7);
      for (int c = 0; c < 4; c++) begin
         go(1'b0, 1'b0, `HB_ADDR_CHAN_PTR, 8'(c), 3'h7);
         go(1'b0, 1'b0, 7'h50, mem[c] ^ 8'h5A, 3'h7);
         go(1'b0, 1'b0, `HB_ADDR_VEC_BASE, 8'hA0 + 8'(c), 3'h7);
      end
      for (int c = 3; c >= 0; c--) begin
         go(1'b0, 1'b0, `HB_ADDR_CHAN_PTR, 8'(c), 3'h7);
         rd(1'b0, 7'h50, mem[c] ^ 8'h5A, 3'h7);
      end
      @(posedge mclk_in) #1;
      modem = 4'($urandom);
      rd(1'b0, `HB_ADDR_MODEM, {4'h0, modem}, 3'h7);
      go(1'b0, 1'b0, `HB_ADDR_SVC_STATUS, 8'h05, 3'h7);
      check("request pins", 8'h02, {5'h00, sreq_n});
      rd(1'b0, `HB_ADDR_SVC_STATUS, 8'h05, 3'h7);
      host.offer(3'h5, p);
      check("chain pass", 8'h00, {7'h00, p});
      chan = 2'($urandom);
      rd(1'b1, 7'h00, 8'hA0 + 8'(chan), 3'h6);
      go(1'b0, 1'b0, 7'h01, 8'h33, 3'h7);
      check("service hold-off", 8'h01, 8'(lat > `HB_HOLDOFF_CYC - 10));
      go(1'b0, 1'b0, `HB_ADDR_SVC_END, 8'h00, 3'h7);
      rd(1'b0, 7'h01, 8'h33, 3'h7);
      check("end hold-off", 8'h01, 8'(lat > `HB_HOLDOFF_CYC - 10));
      go(1'b0, 1'b0, `HB_ADDR_SVC_STATUS, 8'h02, 3'h7);
      go(1'b0, 1'b0, 7'h41, 8'hC5, 3'h7);
      rd(1'b1, 7'h00, 8'hC5, 3'h5);
      tally_and_finish();
   end
endmodule // testbench
